// ---- logic/sse_pkg.sv ----
// Constants and state-word layout for the supply sequencing engine
// Behaviour
// - Up to 63 programmable states, each a complete self-contained definition.
// - Every state watches eight supply fault detector status inputs.
// - Any state may name any other state as its next state.
// - Each state has sequence, monitor and timeout exits with own targets.
// - Sequence delay and timeout set per state, reloaded each change, 0 to 400 ms.
// - All eight output levels come from the current state and stay fixed.
// - A state change, including the fetch, completes in under 20 us.
// - All warning sources ORed into one warning offered to the sequence and monitor exits.
// - Host jump command forces an unconditional advance via the sequence path.
// - Sequence exit taken when the selected input reaches its expected level.
// - Sequence exit may wait a programmed delay, 10 us to 400 ms.
// - Monitor exit is a wide OR of selected inputs off their expected level.
// - Monitor exit has no delay; only the fetch adds latency.
// - Timeout exit when sequence condition is not met within programmed time.
// - Fault latch over two registers, one bit per input, set on fault.
// - Host can read the fault latch to find which inputs faulted.
// - Fault latching enabled or disabled by a per-state bit.
// - After configuration load completes, wait 0.5 ms, then fetch first state.
// - Each state is one 64-bit word of 64 slots, one slot reserved.
// - Dual-function detectors in digital mode act as secondary warnings.
package sse_pkg;
	localparam int CLK_HZ          = 10_000_000;
	localparam int T_FETCH_MAX_US  = 20;
	localparam int FETCH_MAX_CYC   = T_FETCH_MAX_US * (CLK_HZ / 1_000_000);
	localparam int T_CFG_WAIT_US   = 500;
	localparam int T_MAX_MS        = 400;
	localparam int T_UNIT0_US      = 10;
	localparam int T_UNIT1_US      = 100;
	localparam int T_UNIT2_US      = 1000;
	localparam int T_UNIT3_US      = 20000;
	localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int UNIT0_CYC       = T_UNIT0_US * CYC_PER_US;
	localparam int UNIT1_CYC       = T_UNIT1_US * CYC_PER_US;
	localparam int CFG_WAIT_CYC    = T_CFG_WAIT_US * CYC_PER_US;
	localparam int UNIT2_CYC       = T_UNIT2_US * CYC_PER_US;
	localparam int UNIT3_CYC       = T_UNIT3_US * CYC_PER_US;
	localparam int MAX_CYC         = T_MAX_MS * 1000 * CYC_PER_US;
	localparam int TMR_W           = 23;
	localparam int NSLOT           = 64;
	localparam logic [5:0] SLOT_RESERVED = 6'h3F;
	localparam logic [5:0] SLOT_FIRST    = 6'h00;
	// State word fields, bit positions
	localparam int F_OUT      = 0;
	localparam int F_SEQ_SRC  = 8;
	localparam int F_SEQ_POL  = 12;
	localparam int F_SEQ_NEXT = 13;
	localparam int F_MON_MASK = 19;
	localparam int F_MON_EXP  = 27;
	localparam int F_MON_WARN = 35;
	localparam int F_MON_NEXT = 36;
	localparam int F_TO_NEXT  = 42;
	localparam int F_SEQ_DLY  = 48;
	localparam int F_TO_DLY   = 55;
	localparam int F_FAULT_EN = 62;
	localparam logic [3:0] SRC_WARN = 4'h8;
	// Register byte offsets
	localparam logic [7:0] A_STATUS   = 8'h00;
	localparam logic [7:0] A_JUMP     = 8'h04;
	localparam logic [7:0] A_FAULT_LO = 8'h08;
	localparam logic [7:0] A_FAULT_HI = 8'h0C;
	localparam logic [7:0] A_MEM_ADDR = 8'h10;
	localparam logic [7:0] A_MEM_LO   = 8'h14;
	localparam logic [7:0] A_MEM_HI   = 8'h18;
	localparam int J_GOTO  = 6;
	localparam int J_FORCE = 7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {SSE_WAIT_CFG, SSE_DELAY, SSE_FETCH, SSE_LOAD, SSE_RUN} sse_phase_e;
endpackage

// ---- logic/sse_state_mem.sv ----
// State definition store, one 64-bit word per slot, registered read
`timescale 1ns/1ps
module sse_state_mem (
	input  wire logic        mclk,
	input  wire logic        wr_en,
	input  wire logic [5:0]  wr_addr,
	input  wire logic [63:0] wr_data,
	input  wire logic        rd_en,
	input  wire logic [5:0]  rd_addr,
	output logic      [63:0] rd_data
);
	import sse_pkg::*;
	logic [63:0] mem [0:NSLOT-1];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// No reset on the read register; the engine only uses it after a fetch
	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // sse_state_mem

// ---- logic/sse_engine.sv ----
// Supply sequencing state engine with AXI4-Lite control
`timescale 1ns/1ps
module sse_engine #(
	parameter int P_CFG_WAIT_CYC = sse_pkg::CFG_WAIT_CYC,
	parameter int P_UNIT2_CYC    = sse_pkg::UNIT2_CYC,
	parameter int P_UNIT3_CYC    = sse_pkg::UNIT3_CYC,
	parameter int P_MAX_CYC      = sse_pkg::MAX_CYC
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        cfg_done,
	input  wire logic        supply_input_1,
	input  wire logic        supply_input_2,
	input  wire logic        supply_input_3,
	input  wire logic        high_voltage_input,
	input  wire logic        dual_function_input_1,
	input  wire logic        dual_function_input_2,
	input  wire logic        dual_function_input_3,
	input  wire logic        dual_function_input_4,
	input  wire logic        adc_warning,
	input  wire logic [3:0]  secondary_warning,
	input  wire logic [3:0]  dual_digital_mode,
	output logic      [7:0]  programmable_output,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import sse_pkg::*;

	sse_phase_e      phase_q;
	logic [TMR_W-1:0] wait_q;
	logic [TMR_W-1:0] elapsed_q;
	logic [TMR_W-1:0] seq_cnt_q;
	logic [63:0]     word_q;
	logic [5:0]      cur_q;
	logic [5:0]      fetch_addr_q;
	logic [63:0]     rd_data;
	logic [7:0]      fault_q;
	logic [7:0]      inputs;
	logic            warning;
	logic            seq_cond;
	logic            seq_hit;
	logic            to_hit;
	logic            mon_hit;
	logic            exit_go;
	logic [5:0]      exit_addr;
	logic [7:0]      fault_set;
	logic [7:0]      fault_clr;
	logic [TMR_W-1:0] seq_dly;
	logic [TMR_W-1:0] to_dly;
	logic            jump_goto_q;
	logic            jump_force_q;
	logic [5:0]      jump_tgt_q;
	logic            running;

	logic [7:0]      aw_addr_q;
	logic            aw_have_q;
	logic [31:0]     w_data_q;
	logic [3:0]      w_strb_q;
	logic            w_have_q;
	logic            wr_fire;
	logic [5:0]      mem_addr_q;
	logic [31:0]     mem_lo_q;
	logic            mem_we;
	logic [63:0]     mem_wdata;

	assign inputs  = {dual_function_input_4, dual_function_input_3, dual_function_input_2,
		dual_function_input_1, high_voltage_input, supply_input_3, supply_input_2, supply_input_1};
	assign warning = adc_warning | (|(secondary_warning & dual_digital_mode));
	assign running = (phase_q == SSE_RUN);

	// Timer code: 5-bit count times one of four units, capped at the range top
	function automatic logic [TMR_W-1:0] tmr_decode(input logic [6:0] code);
		logic [TMR_W-1:0] unit;
		logic [TMR_W-1:0] val;
		unit = '0;
		val  = '0;
		case (code[6:5])
			2'h0: unit = TMR_W'(UNIT0_CYC);
			2'h1: unit = TMR_W'(UNIT1_CYC);
			2'h2: unit = TMR_W'(P_UNIT2_CYC);
			default: unit = TMR_W'(P_UNIT3_CYC);
		endcase
		val = TMR_W'(unit * code[4:0]);
		if (val > TMR_W'(P_MAX_CYC)) begin
			val = TMR_W'(P_MAX_CYC);
		end
		return val;
	endfunction

	assign seq_dly = tmr_decode(word_q[F_SEQ_DLY +: 7]);
	assign to_dly  = tmr_decode(word_q[F_TO_DLY +: 7]);

	// Exit detection
	always_comb begin
		seq_cond = 1'b0;
		if (word_q[F_SEQ_SRC +: 4] == SRC_WARN) begin
			seq_cond = (warning == word_q[F_SEQ_POL]);
		end else if (!word_q[F_SEQ_SRC + 3]) begin
			seq_cond = (inputs[word_q[F_SEQ_SRC +: 3]] == word_q[F_SEQ_POL]);
		end
	end

	// A next slot of the reserved value disables that exit
	assign mon_hit = running && (word_q[F_MON_NEXT +: 6] != SLOT_RESERVED) &&
		((|(word_q[F_MON_MASK +: 8] & (inputs ^ word_q[F_MON_EXP +: 8]))) ||
		(word_q[F_MON_WARN] && warning));
	assign to_hit  = running && (word_q[F_TO_DLY +: 5] != 5'h00) && !seq_cond &&
		(word_q[F_TO_NEXT +: 6] != SLOT_RESERVED) && (elapsed_q >= to_dly);
	assign seq_hit = running && (word_q[F_SEQ_NEXT +: 6] != SLOT_RESERVED) &&
		((seq_cond && (seq_cnt_q >= seq_dly)) || jump_force_q);

	// Monitor over timeout over sequence; a host goto outranks none of them
	always_comb begin
		exit_go   = 1'b0;
		exit_addr = cur_q;
		if (mon_hit) begin
			exit_go   = 1'b1;
			exit_addr = word_q[F_MON_NEXT +: 6];
		end else if (to_hit) begin
			exit_go   = 1'b1;
			exit_addr = word_q[F_TO_NEXT +: 6];
		end else if (seq_hit) begin
			exit_go   = 1'b1;
			exit_addr = word_q[F_SEQ_NEXT +: 6];
		end else if (running && jump_goto_q && (jump_tgt_q != SLOT_RESERVED)) begin
			exit_go   = 1'b1;
			exit_addr = jump_tgt_q;
		end
	end

	// Start-up and fetch sequencing
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q      <= SSE_WAIT_CFG;
			wait_q       <= '0;
			fetch_addr_q <= SLOT_FIRST;
		end else begin
			case (phase_q)
				SSE_WAIT_CFG: begin
					wait_q <= '0;
					if (cfg_done) begin
						phase_q <= SSE_DELAY;
					end
				end
				SSE_DELAY: begin
					wait_q <= wait_q + 1'b1;
					if (wait_q >= TMR_W'(P_CFG_WAIT_CYC - 1)) begin
						phase_q      <= SSE_FETCH;
						fetch_addr_q <= SLOT_FIRST;
					end
				end
				SSE_FETCH: phase_q <= SSE_LOAD;
				SSE_LOAD:  phase_q <= SSE_RUN;
				SSE_RUN: begin
					if (exit_go) begin
						phase_q      <= SSE_FETCH;
						fetch_addr_q <= exit_addr;
					end
				end
				default: phase_q <= SSE_WAIT_CFG;
			endcase
		end
	end

	// Loaded state word, current slot, outputs
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			word_q              <= '0;
			cur_q               <= SLOT_FIRST;
			programmable_output <= 8'h00;
		end else if (phase_q == SSE_LOAD) begin
			word_q              <= rd_data;
			cur_q               <= fetch_addr_q;
			programmable_output <= rd_data[F_OUT +: 8];
		end
	end

	// Timers restart on every entry
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			elapsed_q <= '0;
			seq_cnt_q <= '0;
		end else if (!running) begin
			elapsed_q <= '0;
			seq_cnt_q <= '0;
		end else begin
			if (elapsed_q != {TMR_W{1'b1}}) begin
				elapsed_q <= elapsed_q + 1'b1;
			end
			if (!seq_cond) begin
				seq_cnt_q <= '0;
			end else if (seq_cnt_q != {TMR_W{1'b1}}) begin
				seq_cnt_q <= seq_cnt_q + 1'b1;
			end
		end
	end

	// Fault latch; a new fault wins over a clear in the same cycle
	assign fault_set = (running && word_q[F_FAULT_EN]) ?
		(word_q[F_MON_MASK +: 8] & (inputs ^ word_q[F_MON_EXP +: 8])) : 8'h00;
	always_comb begin
		fault_clr = 8'h00;
		if (wr_fire && w_strb_q[0]) begin
			if (aw_addr_q == A_FAULT_LO) begin
				fault_clr[3:0] = w_data_q[3:0];
			end else if (aw_addr_q == A_FAULT_HI) begin
				fault_clr[7:4] = w_data_q[3:0];
			end
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fault_q <= 8'h00;
		end else begin
			fault_q <= (fault_q & ~fault_clr) | fault_set;
		end
	end

	// Host jump requests, consumed on the next state change
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			jump_goto_q  <= 1'b0;
			jump_force_q <= 1'b0;
			jump_tgt_q   <= SLOT_FIRST;
		end else if (wr_fire && (aw_addr_q == A_JUMP) && w_strb_q[0]) begin
			jump_goto_q  <= w_data_q[J_GOTO];
			jump_force_q <= w_data_q[J_FORCE];
			jump_tgt_q   <= w_data_q[5:0];
		end else if (running && exit_go) begin
			jump_goto_q  <= 1'b0;
			jump_force_q <= 1'b0;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_q)
					A_JUMP, A_FAULT_LO, A_FAULT_HI, A_MEM_ADDR, A_MEM_LO, A_MEM_HI:
						s_axi_bresp <= RESP_OKAY;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// State store staging; the high word commits the whole 64-bit entry
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mem_addr_q <= 6'h00;
			mem_lo_q   <= 32'h0000_0000;
		end else if (wr_fire && (&w_strb_q)) begin
			if (aw_addr_q == A_MEM_ADDR) begin
				mem_addr_q <= w_data_q[5:0];
			end else if (aw_addr_q == A_MEM_LO) begin
				mem_lo_q <= w_data_q;
			end
		end
	end
	assign mem_we    = wr_fire && (&w_strb_q) && (aw_addr_q == A_MEM_HI) && (mem_addr_q != SLOT_RESERVED);
	assign mem_wdata = {w_data_q, mem_lo_q};

	sse_state_mem u_mem (
		.mclk    (mclk),
		.wr_en   (mem_we),
		.wr_addr (mem_addr_q),
		.wr_data (mem_wdata),
		.rd_en   (phase_q == SSE_FETCH),
		.rd_addr (fetch_addr_q),
		.rd_data (rd_data)
	);

	// AXI4-Lite read path, one outstanding read
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				A_STATUS:   s_axi_rdata <= {22'h0, warning, running, 2'h0, cur_q};
				A_JUMP:     s_axi_rdata <= {24'h0, jump_force_q, jump_goto_q, jump_tgt_q};
				A_FAULT_LO: s_axi_rdata <= {28'h0, fault_q[3:0]};
				A_FAULT_HI: s_axi_rdata <= {28'h0, fault_q[7:4]};
				A_MEM_ADDR: s_axi_rdata <= {26'h0, mem_addr_q};
				A_MEM_LO:   s_axi_rdata <= mem_lo_q;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	property p_out_hold;
		@(posedge mclk) disable iff (!reset_n)
		(phase_q != SSE_LOAD) |=> $stable(programmable_output);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("outputs moved outside a load");

	property p_low_till_load;
		@(posedge mclk) disable iff (!reset_n)
		(phase_q == SSE_WAIT_CFG || phase_q == SSE_DELAY) |-> (programmable_output == 8'h00) && !exit_go;
	endproperty
	a_low_till_load: assert property (p_low_till_load) else $error("output or exit before first load");

	property p_fetch_time;
		@(posedge mclk) disable iff (!reset_n)
		(phase_q == SSE_FETCH) |=> (phase_q == SSE_LOAD) ##1 (phase_q == SSE_RUN);
	endproperty
	a_fetch_time: assert property (p_fetch_time) else $error("state fetch too slow");

	property p_mon_first;
		@(posedge mclk) disable iff (!reset_n)
		mon_hit |=> (phase_q == SSE_FETCH) && (fetch_addr_q == $past(word_q[F_MON_NEXT +: 6]));
	endproperty
	a_mon_first: assert property (p_mon_first) else $error("monitor exit not taken at once");

	property p_to_over_seq;
		@(posedge mclk) disable iff (!reset_n)
		(to_hit && !mon_hit) |=> (fetch_addr_q == $past(word_q[F_TO_NEXT +: 6]));
	endproperty
	a_to_over_seq: assert property (p_to_over_seq) else $error("timeout exit target wrong");

	property p_seq_exit;
		@(posedge mclk) disable iff (!reset_n)
		(seq_hit && !to_hit && !mon_hit) |=> (fetch_addr_q == $past(word_q[F_SEQ_NEXT +: 6]));
	endproperty
	a_seq_exit: assert property (p_seq_exit) else $error("sequence exit target wrong");

	property p_fault_set;
		@(posedge mclk) disable iff (!reset_n)
		(running && word_q[F_FAULT_EN] && inputs[2] != word_q[F_MON_EXP + 2] && word_q[F_MON_MASK + 2]) |=> fault_q[2];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault bit not latched");

	property p_cfg_wait;
		@(posedge mclk) disable iff (!reset_n)
		$rose(phase_q == SSE_DELAY) |-> (phase_q == SSE_DELAY)[*8];
	endproperty
	a_cfg_wait: assert property (p_cfg_wait) else $error("first fetch came too early");

	property p_seq_delay;
		@(posedge mclk) disable iff (!reset_n)
		(seq_hit && !jump_force_q) |-> (seq_cnt_q >= seq_dly) && (elapsed_q >= seq_dly);
	endproperty
	a_seq_delay: assert property (p_seq_delay) else $error("sequence exit before its delay");
endmodule // sse_engine

// ---- tb/sse_det_model.sv ----
// Behavioural model of the eight supply fault detectors feeding the engine
`timescale 1ns/1ps
module sse_det_model #(
	parameter int FILT = 2
) (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic [7:0] req,
	output logic      [7:0] st
);
	logic [7:0] last_q;
	int         cnt_q;

	// Glitch filter: a level must settle before the engine sees it, as the real detectors do
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= 8'h00;
			last_q <= 8'h00;
			cnt_q <= 0;
		end else if (req != last_q) begin
			last_q <= req;
			cnt_q <= 0;
		end else if (cnt_q < FILT) begin
			cnt_q <= cnt_q + 1;
		end else begin
			st <= last_q;
		end
	end
endmodule // sse_det_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the supply sequencing engine
`timescale 1ns/1ps
module tb_top;
	import sse_pkg::*;
	localparam int CFGW = 10;
	localparam int U2   = 20;
	localparam int MAXC = 100;
	logic        mclk, reset_n, cfg_done, adc_warning;
	logic [3:0]  secondary_warning, dual_digital_mode;
	logic [7:0]  req, st, programmable_output, awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp;
	logic [7:0]  out_e [64];
	int          num_errors, comparisons, seed, n, t;

	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	sse_det_model u_det (.mclk(mclk), .reset_n(reset_n), .req(req), .st(st));

	// Strobes and response readies held constant: the master never stalls a response
	sse_engine #(.P_CFG_WAIT_CYC(CFGW), .P_UNIT2_CYC(U2), .P_UNIT3_CYC(40), .P_MAX_CYC(MAXC)) dut (
		.mclk(mclk), .reset_n(reset_n), .cfg_done(cfg_done), .supply_input_1(st[0]), .supply_input_2(st[1]),
		.supply_input_3(st[2]), .high_voltage_input(st[3]), .dual_function_input_1(st[4]),
		.dual_function_input_2(st[5]), .dual_function_input_3(st[6]), .dual_function_input_4(st[7]),
		.adc_warning(adc_warning), .secondary_warning(secondary_warning), .dual_digital_mode(dual_digital_mode),
		.programmable_output(programmable_output), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1));

	task automatic results();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic hang();
		num_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		results();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask

	// Ready is looked at mid-cycle, where it equals its value at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		bit ta, tw, tb;
		int i;
		ta = 0;
		tw = 0;
		tb = 0;
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= v;
		wvalid <= 1'h1;
		for (i = 0; i < 40 && !tb; i++) begin
			@(negedge mclk);
			ta |= awready;
			tw |= wready;
			tb = bvalid;
			if (tb) chk(32'(bresp), 32'(er));
			@(posedge mclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		if (!tb) hang();
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		bit ta, tr;
		int i;
		ta = 0;
		tr = 0;
		v = 32'h0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		for (i = 0; i < 40 && !tr; i++) begin
			@(negedge mclk);
			ta |= arready;
			tr = rvalid;
			if (tr) v = rdata;
			if (tr) chk(32'(rresp), 32'(er));
			@(posedge mclk);
			if (ta) arvalid <= 1'h0;
		end
		if (!tr) hang();
	endtask

	task automatic set_in(input logic [7:0] v);
		int i;
		@(posedge mclk);
		req <= v;
		for (i = 0; i < 20 && st !== v; i++) @(negedge mclk);
		if (st !== v) hang();
	endtask

	// Every slot has a distinct output pattern, so the pattern tells which slot is live
	task automatic wait_out(input int s, input int lim);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
			if (n > lim) hang();
		end while (programmable_output !== out_e[s]);
	endtask

	task automatic chk_slot(input int s);
		rd(A_STATUS, RESP_OKAY, d);
		chk(32'(d[8:0]), 32'h100 | 32'(s));
	endtask

	function automatic logic [63:0] sw(input int s, input int src, input int pol, input int sn, input int mm,
			input int mn, input int tn, input int sd, input int td, input int fe);
		logic [63:0] w;
		w = 64'h0;
		w[F_OUT+:8] = out_e[s];
		w[F_SEQ_SRC+:4] = 4'(src);
		w[F_SEQ_POL] = 1'(pol);
		w[F_SEQ_NEXT+:6] = 6'(sn);
		w[F_MON_MASK+:8] = 8'(mm);
		w[F_MON_EXP+:8] = 8'(mm);
		w[F_MON_NEXT+:6] = 6'(mn);
		w[F_TO_NEXT+:6] = 6'(tn);
		w[F_SEQ_DLY+:7] = 7'(sd);
		w[F_TO_DLY+:7] = 7'(td);
		w[F_FAULT_EN] = 1'(fe);
		return w;
	endfunction

	function automatic logic [63:0] word_of(input int s);
		case (s)
			0: return sw(s, 0, 1, 1, 0, 63, 63, 0, 0, 0);
			1: return sw(s, 1, 1, 2, 1, 3, 63, 0, 0, 0);
			2: return sw(s, 9, 0, 63, 0, 63, 4, 0, 'h7F, 0);
			3: return sw(s, 9, 0, 63, 4, 5, 63, 0, 0, 1);
			5: return sw(s, 9, 0, 63, 0, 63, 6, 0, 'h43, 0);
			6: return sw(s, 8, 1, 7, 0, 63, 63, 0, 0, 0);
			7: return sw(s, 8, 0, 8, 0, 63, 63, 0, 0, 0);
			8: return sw(s, 9, 0, 63, 4, 9, 63, 0, 0, 0);
			9: return sw(s, 9, 0, 10, 0, 63, 63, 0, 0, 0);
			10: return sw(s, 3, 1, 2, 0, 63, 63, 1, 0, 0);
			default: return sw(s, 9, 0, 63, 0, 63, 63, 0, 0, 0);
		endcase
	endfunction

	task automatic prog(input int s);
		logic [63:0] w;
		w = word_of(s);
		wr(A_MEM_ADDR, 32'(s), RESP_OKAY);
		wr(A_MEM_LO, w[31:0], RESP_OKAY);
		wr(A_MEM_HI, w[63:32], RESP_OKAY);
	endtask

	initial begin
		#2_000_000;
		hang();
	end

	initial begin
		seed = 53065;
		num_errors = 0;
		comparisons = 0;
		reset_n = 1'h0;
		cfg_done = 1'h0;
		adc_warning = 1'h0;
		secondary_warning = 4'h0;
		dual_digital_mode = 4'h0;
		req = 8'h04;
		awaddr = 8'h00;
		araddr = 8'h00;
		awvalid = 1'h0;
		wvalid = 1'h0;
		arvalid = 1'h0;
		wdata = 32'h0;
		for (int s = 0; s < 64; s++) out_e[s] = {1'($random(seed)), 1'h1, 6'(s)};
		repeat (3) @(posedge mclk);
		reset_n <= 1'h1;
		for (int s = 0; s < 63; s++) prog(s);
		rd(8'h1C, RESP_SLVERR, d);
		chk(d, 32'h0);
		wr(A_STATUS, 32'h1, RESP_SLVERR);
		rd(A_MEM_HI, RESP_SLVERR, d);
		rd(A_STATUS, RESP_OKAY, d);
		chk(32'(d[8]), 32'h0);
		chk(32'(programmable_output), 32'h0);
		done("idle");
		@(posedge mclk);
		cfg_done <= 1'h1;
		wait_out(0, 40);
		chk(32'(n), 32'(CFGW + 4));
		chk_slot(0);
		set_in(8'h05);
		wait_out(1, 6);
		chk(32'(n < 5), 32'h1);
		set_in(8'h06);
		wait_out(3, 6);
		chk(32'(n < 5), 32'h1);
		set_in(8'h02);
		wait_out(5, 6);
		wait_out(6, 80);
		chk(32'(n >= 3 * U2 && n <= 3 * U2 + 6), 32'h1);
		rd(A_FAULT_LO, RESP_OKAY, d);
		chk(32'(d[3:0]), 32'h4);
		wr(A_FAULT_LO, 32'h4, RESP_OKAY);
		rd(A_FAULT_LO, RESP_OKAY, d);
		chk(32'(d[3:0]), 32'h0);
		done("exits");
		@(posedge mclk);
		secondary_warning <= 4'h1;
		repeat (10) @(negedge mclk);
		chk(32'(programmable_output), 32'(out_e[6]));
		@(posedge mclk);
		dual_digital_mode <= 4'h1;
		wait_out(7, 6);
		@(posedge mclk);
		adc_warning <= 1'h1;
		secondary_warning <= 4'h0;
		repeat (10) @(negedge mclk);
		chk(32'(programmable_output), 32'(out_e[7]));
		@(posedge mclk);
		adc_warning <= 1'h0;
		wait_out(8, 6);
		wait_out(9, 6);
		rd(A_FAULT_LO, RESP_OKAY, d);
		chk(32'(d[3:0]), 32'h0);
		done("warnings");
		wr(A_JUMP, 32'h80, RESP_OKAY);
		wait_out(10, 8);
		rd(A_JUMP, RESP_OKAY, d);
		chk(32'(d[7:6]), 32'h0);
		set_in(8'h0A);
		wait_out(2, UNIT0_CYC + 30);
		chk(32'(n >= UNIT0_CYC && n <= UNIT0_CYC + 6), 32'h1);
		// Longest timeout code runs into the range cap
		wait_out(4, MAXC + 20);
		chk(32'(n), 32'(MAXC + 3));
		// Random slots beyond the scripted chain, reached only by host jumps
		for (int k = 0; k < 12; k++) begin
			t = 11 + ({$random(seed)} % 52);
			wr(A_JUMP, 32'h40 | 32'(t), RESP_OKAY);
			wait_out(t, 8);
			repeat (5) @(negedge mclk);
			chk(32'(programmable_output), 32'(out_e[t]));
			chk_slot(t);
		end
		done("jumps");
		// Reset in mid-run: outputs drop, store survives, start-up wait repeats
		@(posedge mclk);
		reset_n <= 1'h0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'h1;
		@(negedge mclk);
		chk(32'(programmable_output), 32'h0);
		wait_out(0, 40);
		chk(32'(n), 32'(CFGW + 3));
		done("reset");
		results();
	end
endmodule // tb_top
